// ===== inc/pin_event_pkg.sv
// constants for the pin and timing event status block
// assumes a single register clock and one word-wide register access port
package pin_event_pkg;

  // register port
  localparam int          ADDR_W             = 5;
  localparam int          DATA_W             = 16;

  // register indices on the management port
  localparam logic [4:0]  ADDR_PIN_CTRL_ONE  = 5'h01;
  localparam logic [4:0]  ADDR_PIN_CTRL_TWO  = 5'h02;
  localparam logic [4:0]  ADDR_PIN_STATUS    = 5'h03;
  localparam logic [4:0]  ADDR_TIMING_FLAGS  = 5'h04;
  localparam logic [4:0]  ADDR_TIMING_EN     = 5'h05;

  // values after reset
  localparam logic [15:0] PIN_CTRL_ONE_RESET = 16'h6c00;
  localparam logic [15:0] PIN_CTRL_TWO_RESET = 16'h0000;
  localparam logic [15:0] TIMING_EN_RESET    = 16'h0000;

  // writable bits
  localparam logic [15:0] PIN_CTRL_ONE_WMASK = 16'h7fff;
  localparam logic [15:0] PIN_CTRL_TWO_WMASK = 16'h3fff;
  localparam logic [15:0] TIMING_EN_WMASK    = 16'h3fff;

  // pin status word layout
  localparam int          NUM_PINS           = 7;
  localparam int          UPPER_PIN_FIRST    = 3;
  localparam int          PIN_LEVEL_LSB      = 0;
  localparam int          PIN_LATCH_LSB      = 8;
  localparam int          EDGE_UPPER_BIT     = 13;
  localparam int          EDGE_LOWER_BIT     = 12;

  // timing flag word layout
  localparam int          SUM_MAIN_BIT       = 15;
  localparam int          SUM_OWN_BIT        = 14;
  localparam int          NUM_STAMP          = 3;
  localparam int          STAMP_FILLED_LSB   = 8;
  localparam int          STAMP_OVF_LSB      = 9;
  localparam int          GEN2_FREED_BIT     = 6;
  localparam int          GEN2_SEQ_BIT       = 5;
  localparam int          GEN2_MARK_BIT      = 4;
  localparam int          GEN1_FREED_BIT     = 3;
  localparam logic [15:0] TIMING_LATCH_MASK  = 16'h3f78;

  // reset release: cycles until the pin edge detector holds two valid samples
  localparam int          ARM_CYCLES         = 3;

endpackage

// ===== inc/flag_bank_if.sv
// set, clear and stored flags between the status block and its latch banks
// assumes both ends share the register clock
`timescale 1ns/1ps
interface flag_bank_if #(parameter int W = 16);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// ===== core/latch_bank.sv
// bank of sticky flags, set by events and cleared by reads
// assumes set and clr are synchronous to i_core_clk
`timescale 1ns/1ps
module latch_bank #(
  parameter int W = 16
) (
  input  wire logic      i_core_clk, // register clock
  input  wire logic      i_rstn,     // synchronous reset, active low
  flag_bank_if.bank      fb          // set, clear and flags
);

  logic [W-1:0] flags_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rstn)
          flags_ff[g] <= 1'b0;
        else if (fb.set[g])
          flags_ff[g] <= 1'b1; // RL16
        else if (fb.clr[g])
          flags_ff[g] <= 1'b0; // RL3
      end
    end
  endgenerate

  assign fb.flags = flags_ff;

endmodule

// ===== core/pin_event_status.sv
// pin edge latches, live pin levels and timing event flags with summaries
// assumes pins are asynchronous; all event inputs come from logic on i_core_clk
// Function
// RL1 - upper pins latch on selected edge
// RL2 - lower pins latch on selected edge
// RL3 - pin flag shows edge since read; clears
// RL4 - low bits show live pin levels
// RL5 - bit 15 summarises main event flags
// RL6 - bit 14 summarises enabled timing flags
// RL7 - queue overflow latched until read
// RL8 - queue empty-to-filled latched, read clears
// RL9 - generator queue full-to-not-full latched
// RL10 - generator two sequence end latched
// RL11 - only marked generator two events latch
// RL12 - enabled flags drive interrupt toward pin
// RL13 - reserved bits read as zero
// RL14 - edge select: 0 falling, 1 rising
// RL15 - per-flag enable gates the summary
// RL16 - event during read keeps flag set
`timescale 1ns/1ps
module pin_event_status (
  input  wire logic        i_core_clk,        // register clock, 40 MHz
  input  wire logic        i_rstn,            // synchronous reset, active low
  input  wire logic        i_reg_rd,          // register read strobe, one cycle
  input  wire logic        i_reg_wr,          // register write strobe, one cycle
  input  wire logic [4:0]  i_reg_addr,        // register index
  input  wire logic [15:0] i_reg_wdata,       // write data
  output logic      [15:0] o_reg_rdata,       // read data, valid with o_reg_rvalid
  output logic             o_reg_rvalid,      // read answer, one cycle
  input  wire logic [6:0]  i_pin,             // pins seven down to one, asynchronous
  input  wire logic [2:0]  i_stamp_overflow,  // stamp queue overflow pulses, queues 3..1
  input  wire logic [2:0]  i_stamp_not_empty, // stamp queue not-empty levels, queues 3..1
  input  wire logic [1:0]  i_gen_queue_full,  // generator command queue full, gen 2..1
  input  wire logic        i_gen2_seq_done,   // generator two repeat sequence done pulse
  input  wire logic        i_gen2_event_done, // generator two event done pulse
  input  wire logic        i_gen2_event_mark, // status mark bit of that event's entry
  input  wire logic        i_main_irq_src,    // any enabled main event flag set
  output logic             o_timing_irq,      // interrupt request toward the pin mux
  output logic      [15:0] o_pin_ctrl_one,    // pin output control one
  output logic      [15:0] o_pin_ctrl_two     // pin output control two
);

  flag_bank_if #(.W(pin_event_pkg::NUM_PINS)) pin_if ();
  flag_bank_if #(.W(pin_event_pkg::DATA_W))   tim_if ();

  logic [6:0]  pin_s1_ff;
  logic [6:0]  pin_s2_ff;
  logic [6:0]  pin_s3_ff;
  logic [2:0]  arm_ff;
  logic [2:0]  stamp_ne_prev_ff;
  logic [1:0]  gen_full_prev_ff;
  logic [15:0] ctrl_one_ff;
  logic [15:0] ctrl_two_ff;
  logic [15:0] tim_en_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic        irq_ff;
  logic [15:0] nxt_rdata;
  logic [6:0]  pin_set;
  logic [15:0] tim_set;
  logic [2:0]  stamp_fill;
  logic        armed;
  logic        rd_pin;
  logic        rd_tim;
  logic        own_sum;

  latch_bank #(.W(pin_event_pkg::NUM_PINS)) u_pin_bank (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .fb         (pin_if.bank)
  );

  latch_bank #(.W(pin_event_pkg::DATA_W)) u_tim_bank (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .fb         (tim_if.bank)
  );

  // pins: two stages against metastability, third stage only for edge compare
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      pin_s1_ff <= 7'h00;
      pin_s2_ff <= 7'h00;
      pin_s3_ff <= 7'h00;
    end
    else
    begin
      pin_s1_ff <= i_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // edges are ignored until both compare stages hold real pin samples,
  // otherwise a pin held high through reset would look like a rising edge
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      arm_ff <= 3'h0;
    else
      arm_ff <= {arm_ff[1:0], 1'b1};
  end

  assign armed = arm_ff[pin_event_pkg::ARM_CYCLES-1];

  genvar p;
  generate
    for (p = 0; p < pin_event_pkg::NUM_PINS; p++)
    begin : g_pin
      logic sel_rise;
      assign sel_rise = (p >= pin_event_pkg::UPPER_PIN_FIRST) ?
                        ctrl_two_ff[pin_event_pkg::EDGE_UPPER_BIT] :   // RL1
                        ctrl_two_ff[pin_event_pkg::EDGE_LOWER_BIT];    // RL2
      assign pin_set[p] = armed & (sel_rise ? (pin_s2_ff[p] & ~pin_s3_ff[p]) :
                                              (~pin_s2_ff[p] & pin_s3_ff[p])); // RL14
    end
  endgenerate

  assign rd_pin = i_reg_rd && (i_reg_addr == pin_event_pkg::ADDR_PIN_STATUS);
  assign rd_tim = i_reg_rd && (i_reg_addr == pin_event_pkg::ADDR_TIMING_FLAGS);

  assign pin_if.set = pin_set;
  assign pin_if.clr = {pin_event_pkg::NUM_PINS{rd_pin}}; // RL3

  // event history for the transition-triggered timing flags
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      stamp_ne_prev_ff <= 3'h0;
      gen_full_prev_ff <= 2'h0;
    end
    else
    begin
      stamp_ne_prev_ff <= i_stamp_not_empty;
      gen_full_prev_ff <= i_gen_queue_full;
    end
  end

  assign stamp_fill = i_stamp_not_empty & ~stamp_ne_prev_ff; // RL8

  always_comb
  begin
    tim_set = 16'h0000;
    for (int k = 0; k < pin_event_pkg::NUM_STAMP; k++)
    begin
      tim_set[pin_event_pkg::STAMP_OVF_LSB + 2*k]    = i_stamp_overflow[k]; // RL7
      tim_set[pin_event_pkg::STAMP_FILLED_LSB + 2*k] = stamp_fill[k];       // RL8
    end
    tim_set[pin_event_pkg::GEN2_FREED_BIT] = gen_full_prev_ff[1] & ~i_gen_queue_full[1]; // RL9
    tim_set[pin_event_pkg::GEN1_FREED_BIT] = gen_full_prev_ff[0] & ~i_gen_queue_full[0]; // RL9
    tim_set[pin_event_pkg::GEN2_SEQ_BIT]   = i_gen2_seq_done;                            // RL10
    tim_set[pin_event_pkg::GEN2_MARK_BIT]  = i_gen2_event_done & i_gen2_event_mark;      // RL11
  end

  assign tim_if.set = tim_set;
  assign tim_if.clr = {pin_event_pkg::DATA_W{rd_tim}} & pin_event_pkg::TIMING_LATCH_MASK; // RL7

  assign own_sum = |(tim_if.flags & tim_en_ff & pin_event_pkg::TIMING_LATCH_MASK); // RL15

  // writable controls
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      ctrl_one_ff <= pin_event_pkg::PIN_CTRL_ONE_RESET;
      ctrl_two_ff <= pin_event_pkg::PIN_CTRL_TWO_RESET;
      tim_en_ff   <= pin_event_pkg::TIMING_EN_RESET;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        pin_event_pkg::ADDR_PIN_CTRL_ONE: ctrl_one_ff <= i_reg_wdata & pin_event_pkg::PIN_CTRL_ONE_WMASK;
        pin_event_pkg::ADDR_PIN_CTRL_TWO: ctrl_two_ff <= i_reg_wdata & pin_event_pkg::PIN_CTRL_TWO_WMASK;
        pin_event_pkg::ADDR_TIMING_EN:    tim_en_ff   <= i_reg_wdata & pin_event_pkg::TIMING_EN_WMASK;
        default:                          ctrl_one_ff <= ctrl_one_ff;
      endcase
    end
  end

  // read data: value before the clear that the same read performs
  always_comb
  begin
    nxt_rdata = 16'h0000;
    case (i_reg_addr)
      pin_event_pkg::ADDR_PIN_CTRL_ONE: nxt_rdata = ctrl_one_ff;
      pin_event_pkg::ADDR_PIN_CTRL_TWO: nxt_rdata = ctrl_two_ff;
      pin_event_pkg::ADDR_PIN_STATUS:
      begin
        nxt_rdata[pin_event_pkg::PIN_LATCH_LSB +: pin_event_pkg::NUM_PINS] = pin_if.flags; // RL3
        nxt_rdata[pin_event_pkg::PIN_LEVEL_LSB +: pin_event_pkg::NUM_PINS] = pin_s2_ff;    // RL4
      end
      pin_event_pkg::ADDR_TIMING_FLAGS:
      begin
        nxt_rdata = tim_if.flags & pin_event_pkg::TIMING_LATCH_MASK; // RL13
        nxt_rdata[pin_event_pkg::SUM_MAIN_BIT] = i_main_irq_src;     // RL5
        nxt_rdata[pin_event_pkg::SUM_OWN_BIT]  = own_sum;            // RL6
      end
      pin_event_pkg::ADDR_TIMING_EN:    nxt_rdata = tim_en_ff;
      default:                          nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= i_reg_rd;
      if (i_reg_rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // interrupt level toward the pin output mux
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      irq_ff <= 1'b0;
    else
      irq_ff <= own_sum; // RL12
  end

  assign o_reg_rdata    = rdata_ff;
  assign o_reg_rvalid   = rvalid_ff;
  assign o_timing_irq   = irq_ff;
  assign o_pin_ctrl_one = ctrl_one_ff;
  assign o_pin_ctrl_two = ctrl_two_ff;

  a_upper_edge_latch: assert property ( // RL1
    @(posedge i_core_clk) disable iff (!i_rstn)
    (pin_set[6:3] != 4'h0) |=> ((pin_if.flags[6:3] & $past(pin_set[6:3])) == $past(pin_set[6:3])))
    else $error("upper pin edge not latched");

  a_lower_edge_latch: assert property ( // RL2
    @(posedge i_core_clk) disable iff (!i_rstn)
    (pin_set[2:0] != 3'h0) |=> ((pin_if.flags[2:0] & $past(pin_set[2:0])) == $past(pin_set[2:0])))
    else $error("lower pin edge not latched");

  a_pin_read_clear: assert property ( // RL3
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_pin && pin_set == 7'h00) |=> (pin_if.flags == 7'h00) ##0 o_reg_rvalid
      ##0 (o_reg_rdata[14:8] == $past(pin_if.flags)))
    else $error("pin flag read did not return and clear");

  a_pin_live_level: assert property ( // RL4
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_pin |=> (o_reg_rdata[6:0] == $past(pin_s2_ff)))
    else $error("pin level bits wrong");

  a_main_summary: assert property ( // RL5
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_tim |=> (o_reg_rdata[15] == $past(i_main_irq_src)))
    else $error("main summary bit wrong");

  a_own_summary: assert property ( // RL6
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_tim |=> (o_reg_rdata[14] == $past(|(tim_if.flags & tim_en_ff & 16'h3f78))))
    else $error("own summary bit wrong");

  a_overflow_held: assert property ( // RL7
    @(posedge i_core_clk) disable iff (!i_rstn)
    (tim_if.flags[9] && !rd_tim) |=> tim_if.flags[9])
    else $error("overflow flag dropped without read");

  a_overflow_latch: assert property ( // RL7
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_stamp_overflow != 3'h0) |=>
      (({tim_if.flags[13], tim_if.flags[11], tim_if.flags[9]} & $past(i_stamp_overflow)) == $past(i_stamp_overflow)))
    else $error("overflow not latched");

  a_filled_latch: assert property ( // RL8
    @(posedge i_core_clk) disable iff (!i_rstn)
    $rose(i_stamp_not_empty[2]) |=> tim_if.flags[12])
    else $error("queue three fill not latched");

  a_freed_latch: assert property ( // RL9
    @(posedge i_core_clk) disable iff (!i_rstn)
    $fell(i_gen_queue_full[0]) |=> tim_if.flags[3])
    else $error("generator one queue space not latched");

  a_sequence_latch: assert property ( // RL10
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_gen2_seq_done |=> tim_if.flags[5])
    else $error("sequence done not latched");

  a_unmarked_ignored: assert property ( // RL11
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!tim_if.flags[4] && !(i_gen2_event_done && i_gen2_event_mark)) |=> !tim_if.flags[4])
    else $error("marked event flag set without marked event");

  a_irq_follows: assert property ( // RL12
    @(posedge i_core_clk) disable iff (!i_rstn)
    ((tim_if.flags & tim_en_ff & 16'h3f78) != 16'h0000) |=> o_timing_irq)
    else $error("interrupt not raised for enabled flag");

  a_reserved_zero: assert property ( // RL13
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_pin || rd_tim) |=> (o_reg_rdata[7] == 1'b0) && ($past(rd_tim) || !o_reg_rdata[15]))
    else $error("reserved bit not zero");

  a_edge_polarity: assert property ( // RL14
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!ctrl_two_ff[12] && pin_s2_ff[0] && !pin_s3_ff[0]) |-> !pin_set[0])
    else $error("rising edge latched under falling select");

  a_enable_gate: assert property ( // RL15
    @(posedge i_core_clk) disable iff (!i_rstn)
    (tim_en_ff == 16'h0000) |=> !o_timing_irq)
    else $error("interrupt with all enables off");

  a_set_wins: assert property ( // RL16
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_tim && tim_set[9]) |=> tim_if.flags[9])
    else $error("event lost during read");

endmodule

// ===== testbench/reg_host_model.sv
// management host model: issues one-cycle read and write strobes on the register port
// assumes the status block answers a read on the same edge that takes the strobe
`timescale 1ns/1ps
module reg_host_model (
  input  wire logic        i_core_clk,   // register clock
  output logic             o_reg_rd,     // read strobe
  output logic             o_reg_wr,     // write strobe
  output logic      [4:0]  o_reg_addr,   // register index
  output logic      [15:0] o_reg_wdata,  // write data
  input  wire logic [15:0] i_reg_rdata,  // read data
  input  wire logic        i_reg_rvalid  // read answer
);
  initial
  begin
    o_reg_rd    = 1'b0;
    o_reg_wr    = 1'b0;
    o_reg_addr  = 5'h00;
    o_reg_wdata = 16'h0000;
  end

  // strobes are one-cycle pulses: a held strobe would clear flags every cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_core_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(negedge i_core_clk);
    o_reg_rd   = 1'b1;
    o_reg_addr = a;
    @(negedge i_core_clk);
    o_reg_rd   = 1'b0;
    n = 0;
    while (i_reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge i_core_clk);
      n++;
    end
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
  endtask
endmodule

// ===== testbench/pin_event_status_test.sv
// self-checking bench for the pin and timing event status block
// assumes the host model drives the register port; events are driven here
`timescale 1ns/1ps
module pin_event_status_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd, wr, rvalid, irq;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, ctrl_one, ctrl_two, d;
  logic [6:0]  pin = 7'h00;
  logic [2:0]  ovf = 3'h0, not_empty = 3'h0;
  logic [1:0]  qfull = 2'h0;
  logic        seq_done = 1'b0, ev_done = 1'b0, ev_mark = 1'b0, main_src = 1'b0;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #12.5 clk = ~clk;

  reg_host_model host (.i_core_clk(clk), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(addr),
                       .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

  pin_event_status uut (
    .i_core_clk(clk), .i_rstn(rstn), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_pin(pin),
    .i_stamp_overflow(ovf), .i_stamp_not_empty(not_empty), .i_gen_queue_full(qfull),
    .i_gen2_seq_done(seq_done), .i_gen2_event_done(ev_done), .i_gen2_event_mark(ev_mark),
    .i_main_irq_src(main_src), .o_timing_irq(irq), .o_pin_ctrl_one(ctrl_one),
    .o_pin_ctrl_two(ctrl_two));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdchk(input string name, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(a, v);
    chk(name, exp, v);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic test_reset_map;
    chk("ctrl_one out", 16'h6c00, ctrl_one);
    rdchk("ctrl_one", 5'h01, 16'h6c00);
    rdchk("ctrl_two", 5'h02, 16'h0000);
    rdchk("status", 5'h03, 16'h0000);
    rdchk("flags", 5'h04, 16'h0000);
    rdchk("enables", 5'h05, 16'h0000);
    rdchk("unmapped", 5'h1f, 16'h0000);
    host.wr(5'h01, 16'hffff);
    rdchk("ctrl_one mask", 5'h01, 16'h7fff);
    chk("ctrl_one out mask", 16'h7fff, ctrl_one);
    host.wr(5'h02, 16'hffff);
    chk("ctrl_two mask", 16'h3fff, ctrl_two);
    $display("test reset_map done");
  endtask

  task automatic test_pins;
    host.wr(5'h03, 16'hffff);
    host.wr(5'h02, 16'h3000);
    pin = 7'h7f;
    repeat (6) @(negedge clk);
    rdchk("rising latch", 5'h03, 16'h7f7f);
    rdchk("read clears", 5'h03, 16'h007f);
    host.wr(5'h02, 16'h0000);
    pin = 7'h00;
    repeat (6) @(negedge clk);
    rdchk("falling latch", 5'h03, 16'h7f00);
    // only the upper group on rising: lower pins must stay clear
    host.wr(5'h02, 16'h2000);
    pin = 7'h7f;
    repeat (6) @(negedge clk);
    rdchk("upper only", 5'h03, 16'h787f);
    pin = 7'h00;
    $display("test pins done");
  endtask

  task automatic pulse_events;
    @(negedge clk);
    ovf      = 3'h7;
    seq_done = 1'b1;
    ev_done  = 1'b1;
    ev_mark  = 1'b1;
    qfull    = 2'h0;
    not_empty = 3'h7;
    @(negedge clk);
    ovf      = 3'h0;
    seq_done = 1'b0;
    ev_done  = 1'b0;
    ev_mark  = 1'b0;
  endtask

  task automatic test_timing;
    @(negedge clk);
    ev_done = 1'b1;
    @(negedge clk);
    ev_done = 1'b0;
    rdchk("unmarked", 5'h04, 16'h0000);
    host.wr(5'h05, 16'hffff);
    rdchk("enables mask", 5'h05, 16'h3fff);
    qfull = 2'h3;
    repeat (2) @(negedge clk);
    pulse_events();
    main_src = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq on", 16'h0001, {15'h0000, irq});
    rdchk("all flags", 5'h04, 16'hff78);
    rdchk("flags cleared", 5'h04, 16'h8000);
    chk("irq off", 16'h0000, {15'h0000, irq});
    main_src = 1'b0;
    host.wr(5'h05, 16'h0000);
    not_empty = 3'h0;
    // queues full again so that the pulse frees them and sets bits 6 and 3
    qfull = 2'h3;
    pulse_events();
    repeat (2) @(negedge clk);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    rdchk("masked flags", 5'h04, 16'h3f78);
    $display("test timing done");
  endtask

  task automatic test_set_wins;
    fork
      host.rd(5'h04, d);
      begin
        @(negedge clk);
        ovf = 3'h1;
        @(negedge clk);
        ovf = 3'h0;
      end
    join
    chk("read before set", 16'h0000, d);
    host.rd(5'h04, d);
    chk("set wins", 16'h0200, d & 16'h0200);
    $display("test set_wins done");
  endtask

  initial
  begin
    #(25 * 5000);
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    test_reset_map();
    test_pins();
    test_timing();
    test_set_wins();
    results();
  end
endmodule
